// ### logic/irq_status_mask.sv
/*
 * System-bus interrupt status, mask and priority request logic, plus the write split control bit.
 * Assumes event inputs are one-cycle or level pulses synchronous to ref_clk, external lines are
 * levels held by their devices until cleared there, and the register master never overlaps strobes.
 */
// The implementer's own choice: the plain strobed port.
// Contract
// - Split control bit 31 selects burst (0, reset) or split single writes; rest reserved.
// - Normal status bits 21..0 read pending; writing one clears, zero does nothing.
// - Normal status bits 31 and 30 are read-only summaries, unaffected by writes.
// - Normal status bit 31 is OR of error status bits, zero after reset.
// - Normal status bit 30 is OR of external status bits, no fixed reset value.
// - Normal status bits 29..22 reserved; pending bits 21..0 reset to zero.
// - Normal bits 0..5: render ends, vertical blank in/out, horizontal blank in.
// - Normal bits 6..10 list transfer ends; bit 21 punch-through on later revision.
// - Normal bits 11..20 flag the various DMA ends and vertical-blank overrun.
// - External status bits 3..0 read-only device flags; bits 31..4 reserved.
// - External status directly follows source lines, no fixed reset value.
// - Error status bits 31 and 28..0 read pending, write one clears, reset to zero.
// - Error bits 0..5 render and tile faults; 28 sort command; 31 inhibited area.
// - Error bits 6..7 graphics DMA faults; 8..11 peripheral-link faults.
// - Error bits 12..14 drive-bus address, overrun, ROM access faults.
// - Error bits 15..27 expansion-bus address, overrun, timeout and processor timeout.
// - Three normal masks per level 2,4,6, bits 21..0, one enables, reset zero.
// - Any reset leaves every mask cleared so nothing reaches the processor.
// - Per level external and error masks mirror status layouts, reset zero.
module irq_status_mask #(
	parameter bit HAS_PUNCH_THROUGH = 1'b1
) (
	input wire logic ref_clk, // System bus clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire irq_status_mask_pkg::reg_req_s req, // Register port request
	output logic [31:0] rdata, // Read data, cycle after read strobe
	input wire irq_status_mask_pkg::irq_src_s src, // Interrupt event sources
	output logic [2:0] level_req, // Requests for levels 6,4,2 (bit 2..0)
	output logic write_split // Single writes done as split transactions
);
	typedef struct packed {
		logic split;
		logic [irq_status_mask_pkg::NRM_W-1:0] nrm;
		logic [irq_status_mask_pkg::ERR_W-1:0] err;
		irq_status_mask_pkg::level_mask_s [irq_status_mask_pkg::LEVELS-1:0] mask;
		logic [31:0] rdata;
		logic [2:0] lvl;
	} state_s;

	state_s s_q;
	state_s s_d;

	logic [irq_status_mask_pkg::NRM_W-1:0] nrm_impl;
	logic [irq_status_mask_pkg::EXT_W-1:0] ext_now;
	logic [31:0] nrm_view;
	logic [31:0] rd_mux;
	logic [1:0] lvl_idx;
	logic mask_hit;
	logic [1:0] mask_kind;

	// Punch-through bit exists only on the later revision
	assign nrm_impl = HAS_PUNCH_THROUGH ? {1'b1, 21'h1fffff} : {1'b0, 21'h1fffff};
	assign ext_now = src.ext;

	always_comb
	begin
		nrm_view = 32'h00000000;
		nrm_view[irq_status_mask_pkg::NRM_W-1:0] = s_q.nrm;
		nrm_view[irq_status_mask_pkg::ERR_OR_BIT] = |s_q.err;
		nrm_view[irq_status_mask_pkg::EXT_OR_BIT] = |ext_now;
	end

	always_comb
	begin
		mask_hit = 1'b0;
		lvl_idx = 2'h0;
		mask_kind = 2'h0;
		unique case (req.addr)
			irq_status_mask_pkg::ADDR_L2_NRM_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h0;
				mask_kind = 2'h0;
			end
			irq_status_mask_pkg::ADDR_L2_EXT_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h0;
				mask_kind = 2'h1;
			end
			irq_status_mask_pkg::ADDR_L2_ERR_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h0;
				mask_kind = 2'h2;
			end
			irq_status_mask_pkg::ADDR_L4_NRM_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h1;
				mask_kind = 2'h0;
			end
			irq_status_mask_pkg::ADDR_L4_EXT_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h1;
				mask_kind = 2'h1;
			end
			irq_status_mask_pkg::ADDR_L4_ERR_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h1;
				mask_kind = 2'h2;
			end
			irq_status_mask_pkg::ADDR_L6_NRM_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h2;
				mask_kind = 2'h0;
			end
			irq_status_mask_pkg::ADDR_L6_EXT_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h2;
				mask_kind = 2'h1;
			end
			irq_status_mask_pkg::ADDR_L6_ERR_MASK:
			begin
				mask_hit = 1'b1;
				lvl_idx = 2'h2;
				mask_kind = 2'h2;
			end
			default: mask_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		rd_mux = 32'h00000000;
		if (mask_hit)
		begin
			unique case (mask_kind)
				2'h0: rd_mux[irq_status_mask_pkg::NRM_W-1:0] = s_q.mask[lvl_idx].nrm;
				2'h1: rd_mux[irq_status_mask_pkg::EXT_W-1:0] = s_q.mask[lvl_idx].ext;
				default: rd_mux = s_q.mask[lvl_idx].err;
			endcase
		end
		else
		begin
			unique case (req.addr)
				irq_status_mask_pkg::ADDR_SPLIT_CTRL: rd_mux[irq_status_mask_pkg::SPLIT_BIT] = s_q.split;
				irq_status_mask_pkg::ADDR_NRM_STATUS: rd_mux = nrm_view;
				irq_status_mask_pkg::ADDR_EXT_STATUS: rd_mux[irq_status_mask_pkg::EXT_W-1:0] = ext_now;
				irq_status_mask_pkg::ADDR_ERR_STATUS: rd_mux = s_q.err;
				default: rd_mux = 32'h00000000;
			endcase
		end
	end

	always_comb
	begin
		s_d = s_q;
		s_d.rdata = req.rd ? rd_mux : 32'h00000000;
		// Sources set after the write-one clear so a same-cycle event wins
		if (req.wr && req.addr == irq_status_mask_pkg::ADDR_NRM_STATUS)
			s_d.nrm = s_q.nrm & ~req.wdata[irq_status_mask_pkg::NRM_W-1:0];
		s_d.nrm = (s_d.nrm | src.nrm) & nrm_impl;
		if (req.wr && req.addr == irq_status_mask_pkg::ADDR_ERR_STATUS)
			s_d.err = s_q.err & ~req.wdata;
		s_d.err = (s_d.err | src.err) & irq_status_mask_pkg::ERR_IMPL;
		if (req.wr && req.addr == irq_status_mask_pkg::ADDR_SPLIT_CTRL)
			s_d.split = req.wdata[irq_status_mask_pkg::SPLIT_BIT];
		if (req.wr && mask_hit)
		begin
			unique case (mask_kind)
				2'h0: s_d.mask[lvl_idx].nrm = req.wdata[irq_status_mask_pkg::NRM_W-1:0] & nrm_impl;
				2'h1: s_d.mask[lvl_idx].ext = req.wdata[irq_status_mask_pkg::EXT_W-1:0];
				default: s_d.mask[lvl_idx].err = req.wdata & irq_status_mask_pkg::ERR_IMPL;
			endcase
		end
		// Writes to the external status address change nothing: cleared at the device
		for (int i = 0; i < irq_status_mask_pkg::LEVELS; i++)
			s_d.lvl[i] = |(s_d.nrm & s_d.mask[i].nrm) | |(ext_now & s_d.mask[i].ext)
				| |(s_d.err & s_d.mask[i].err);
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q.split <= irq_status_mask_pkg::SPLIT_RESET;
			s_q.nrm <= irq_status_mask_pkg::NRM_RESET;
			s_q.err <= irq_status_mask_pkg::ERR_RESET;
			for (int i = 0; i < irq_status_mask_pkg::LEVELS; i++)
			begin
				s_q.mask[i].nrm <= irq_status_mask_pkg::NRM_MASK_RESET;
				s_q.mask[i].ext <= irq_status_mask_pkg::EXT_MASK_RESET;
				s_q.mask[i].err <= irq_status_mask_pkg::ERR_MASK_RESET;
			end
			s_q.rdata <= 32'h00000000;
			s_q.lvl <= 3'h0;
		end
		else
			s_q <= s_d;
	end

	assign rdata = s_q.rdata;
	assign level_req = s_q.lvl;
	assign write_split = s_q.split;

	sequence seq_nrm_clear;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_NRM_STATUS && req.wdata[0] && !src.nrm[0];
	endsequence

	sequence seq_nrm_read;
		req.rd && req.addr == irq_status_mask_pkg::ADDR_NRM_STATUS;
	endsequence

	AST_SPLIT_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
		req.wr && req.addr == irq_status_mask_pkg::ADDR_SPLIT_CTRL |=> write_split == $past(req.wdata[31]))
		else $error("split bit did not take written value");
	AST_NRM_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_nrm_clear |=> !s_q.nrm[0])
		else $error("normal bit not cleared by write one");
	AST_NRM_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
		src.nrm[3] |=> s_q.nrm[3])
		else $error("normal event not latched");
	AST_NRM_KEEP: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_q.nrm[5] && !(req.wr && req.addr == irq_status_mask_pkg::ADDR_NRM_STATUS) |=> s_q.nrm[5])
		else $error("normal bit lost without clear");
	AST_ERR_SUMMARY: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_nrm_read |=> rdata[31] == $past(|s_q.err))
		else $error("error summary wrong");
	AST_EXT_SUMMARY: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_nrm_read |=> rdata[30] == $past(|src.ext) && rdata[29:22] == 8'h00)
		else $error("external summary wrong");
	AST_EXT_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rstn)
		req.rd && req.addr == irq_status_mask_pkg::ADDR_EXT_STATUS |=> rdata == {28'h0000000, $past(src.ext)})
		else $error("external status does not follow lines");
	AST_ERR_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
		req.wr && req.addr == irq_status_mask_pkg::ADDR_ERR_STATUS && req.wdata[31] && !src.err[31] |=> !s_q.err[31])
		else $error("error bit not cleared");
	AST_ERR_RESERVED: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_q.err[30:29] == 2'h0)
		else $error("reserved error bits set");
	AST_LEVEL_REQ: assert property (@(posedge ref_clk) disable iff (!rstn)
		##1 level_req[0] == (|(s_q.nrm & s_q.mask[0].nrm) | |(s_q.err & s_q.mask[0].err)
			| |($past(src.ext) & s_q.mask[0].ext)))
		else $error("level two request mismatch");
	AST_MASK_GATE: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_q.mask[1] == '0 |-> !level_req[1])
		else $error("request with all masks clear");

	// Decoded register accesses seen by the checks below
	sequence seq_split_read;
		req.rd && req.addr == irq_status_mask_pkg::ADDR_SPLIT_CTRL;
	endsequence

	sequence seq_nrm_write;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_NRM_STATUS;
	endsequence

	sequence seq_err_write;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_ERR_STATUS;
	endsequence

	sequence seq_ext_write;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_EXT_STATUS;
	endsequence

	sequence seq_err_read;
		req.rd && req.addr == irq_status_mask_pkg::ADDR_ERR_STATUS;
	endsequence

	sequence seq_l2_nrm_write;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_L2_NRM_MASK;
	endsequence

	sequence seq_l4_nrm_write;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_L4_NRM_MASK;
	endsequence

	sequence seq_l6_nrm_write;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_L6_NRM_MASK;
	endsequence

	sequence seq_l2_ext_write;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_L2_EXT_MASK;
	endsequence

	sequence seq_l2_err_write;
		req.wr && req.addr == irq_status_mask_pkg::ADDR_L2_ERR_MASK;
	endsequence

	sequence seq_l4_nrm_read;
		req.rd && req.addr == irq_status_mask_pkg::ADDR_L4_NRM_MASK;
	endsequence

	AST_SPLIT_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_split_read |=> rdata[irq_status_mask_pkg::SPLIT_BIT] == $past(write_split) && rdata[30:0] == 31'h00000000)
		else $error("split control read back wrong");
	AST_SPLIT_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
		!(req.wr && req.addr == irq_status_mask_pkg::ADDR_SPLIT_CTRL) |=> $stable(write_split))
		else $error("split bit changed without a write");
	AST_NRM_SUMMARY_RO: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_nrm_write |=> s_q.err == ($past(s_q.err) | ($past(src.err) & irq_status_mask_pkg::ERR_IMPL)))
		else $error("normal status write disturbed error bits");
	AST_NRM_READ_LOW: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_nrm_read |=> rdata[21:0] == $past(s_q.nrm))
		else $error("normal pending bits read back wrong");
	AST_NRM_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_nrm_write ##0 (req.wdata[1] && src.nrm[1]) |=> s_q.nrm[1])
		else $error("normal event lost to a same-cycle clear");
	AST_NRM_ZERO_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_nrm_write ##0 (!req.wdata[4] && s_q.nrm[4]) |=> s_q.nrm[4])
		else $error("normal bit cleared by writing zero");
	AST_NRM_SET_LIST: assert property (@(posedge ref_clk) disable iff (!rstn)
		src.nrm[6] |=> s_q.nrm[6])
		else $error("list transfer event not latched");
	AST_NRM_SET_PUNCH: assert property (@(posedge ref_clk) disable iff (!rstn)
		src.nrm[21] |=> s_q.nrm[21] == HAS_PUNCH_THROUGH)
		else $error("punch-through event handled wrong for this revision");
	AST_NRM_SET_DMA: assert property (@(posedge ref_clk) disable iff (!rstn)
		src.nrm[20] |=> s_q.nrm[20])
		else $error("DMA end event not latched");
	AST_EXT_WRITE_IGNORED: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_ext_write |=> $stable(s_q.mask) && $stable(write_split))
		else $error("external status write changed state");
	AST_ERR_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_err_read |=> rdata == $past(s_q.err))
		else $error("error status read back wrong");
	AST_ERR_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_err_write ##0 (req.wdata[9] && src.err[9]) |=> s_q.err[9])
		else $error("error event lost to a same-cycle clear");
	AST_ERR_ZERO_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_err_write ##0 (!req.wdata[2] && s_q.err[2]) |=> s_q.err[2])
		else $error("error bit cleared by writing zero");
	AST_ERR_KEEP: assert property (@(posedge ref_clk) disable iff (!rstn)
		s_q.err[28] && !(req.wr && req.addr == irq_status_mask_pkg::ADDR_ERR_STATUS) |=> s_q.err[28])
		else $error("error bit lost without clear");
	AST_ERR_SET_TILE: assert property (@(posedge ref_clk) disable iff (!rstn)
		src.err[5] |=> s_q.err[5])
		else $error("tile fault not latched");
	AST_ERR_SET_GFX: assert property (@(posedge ref_clk) disable iff (!rstn)
		src.err[7] |=> s_q.err[7])
		else $error("graphics DMA fault not latched");
	AST_ERR_SET_DRIVE: assert property (@(posedge ref_clk) disable iff (!rstn)
		src.err[14] |=> s_q.err[14])
		else $error("drive bus fault not latched");
	AST_ERR_SET_EXP: assert property (@(posedge ref_clk) disable iff (!rstn)
		src.err[27] |=> s_q.err[27])
		else $error("expansion bus fault not latched");
	AST_L2_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_l2_nrm_write |=> s_q.mask[0].nrm == ($past(req.wdata[21:0]) & nrm_impl))
		else $error("level two normal mask not written");
	AST_L4_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_l4_nrm_write |=> s_q.mask[1].nrm == ($past(req.wdata[21:0]) & nrm_impl))
		else $error("level four normal mask not written");
	AST_L6_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_l6_nrm_write |=> s_q.mask[2].nrm == ($past(req.wdata[21:0]) & nrm_impl))
		else $error("level six normal mask not written");
	AST_L2_EXT_MASK: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_l2_ext_write |=> s_q.mask[0].ext == $past(req.wdata[3:0]))
		else $error("level two external mask not written");
	AST_L2_ERR_MASK: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_l2_err_write |=> s_q.mask[0].err == ($past(req.wdata) & irq_status_mask_pkg::ERR_IMPL))
		else $error("level two error mask not written");
	AST_MASK_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
		seq_l4_nrm_read |=> rdata == {10'h000, $past(s_q.mask[1].nrm)})
		else $error("level four normal mask read back wrong");
	AST_LEVEL4_REQ: assert property (@(posedge ref_clk) disable iff (!rstn)
		##1 level_req[1] == (|(s_q.nrm & s_q.mask[1].nrm) | |(s_q.err & s_q.mask[1].err)
			| |($past(src.ext) & s_q.mask[1].ext)))
		else $error("level four request mismatch");
	AST_LEVEL6_REQ: assert property (@(posedge ref_clk) disable iff (!rstn)
		##1 level_req[2] == (|(s_q.nrm & s_q.mask[2].nrm) | |(s_q.err & s_q.mask[2].err)
			| |($past(src.ext) & s_q.mask[2].ext)))
		else $error("level six request mismatch");
	AST_MASK_RESET: assert property (@(posedge ref_clk)
		!rstn |-> s_q.mask == '0 && level_req == 3'h0)
		else $error("masks or requests not cleared by reset");
	AST_STATUS_RESET: assert property (@(posedge ref_clk)
		!rstn |-> s_q.nrm == irq_status_mask_pkg::NRM_RESET && s_q.err == irq_status_mask_pkg::ERR_RESET && !write_split)
		else $error("status not cleared by reset");
endmodule

// ### logic/irq_status_mask_pkg.sv
/*
 * Register map, field layout and carrier types for the interrupt status and mask block.
 * Assumes a plain register port with byte addresses; the map's base lies in the upper address bits.
 */
package irq_status_mask_pkg;
	localparam int ADDR_W = 32;
	localparam int NRM_W = 22;
	localparam int EXT_W = 4;
	localparam int ERR_W = 32;
	localparam int LEVELS = 3;

	localparam logic [31:0] ADDR_SPLIT_CTRL = 32'h005f68a0;
	localparam logic [31:0] ADDR_NRM_STATUS = 32'h005f6900;
	localparam logic [31:0] ADDR_EXT_STATUS = 32'h005f6904;
	localparam logic [31:0] ADDR_ERR_STATUS = 32'h005f6908;
	localparam logic [31:0] ADDR_L2_NRM_MASK = 32'h005f6910;
	localparam logic [31:0] ADDR_L2_EXT_MASK = 32'h005f6914;
	localparam logic [31:0] ADDR_L2_ERR_MASK = 32'h005f6918;
	localparam logic [31:0] ADDR_L4_NRM_MASK = 32'h005f6920;
	localparam logic [31:0] ADDR_L4_EXT_MASK = 32'h005f6924;
	localparam logic [31:0] ADDR_L4_ERR_MASK = 32'h005f6928;
	localparam logic [31:0] ADDR_L6_NRM_MASK = 32'h005f6930;
	localparam logic [31:0] ADDR_L6_EXT_MASK = 32'h005f6934;
	localparam logic [31:0] ADDR_L6_ERR_MASK = 32'h005f6938;

	localparam int SPLIT_BIT = 31;
	localparam int ERR_OR_BIT = 31;
	localparam int EXT_OR_BIT = 30;

	localparam logic SPLIT_RESET = 1'h0;
	localparam logic [NRM_W-1:0] NRM_RESET = 22'h000000;
	localparam logic [ERR_W-1:0] ERR_RESET = 32'h00000000;
	localparam logic [NRM_W-1:0] NRM_MASK_RESET = 22'h000000;
	localparam logic [EXT_W-1:0] EXT_MASK_RESET = 4'h0;
	localparam logic [ERR_W-1:0] ERR_MASK_RESET = 32'h00000000;
	// Error bits 29 and 30 are reserved and never hold a value
	localparam logic [ERR_W-1:0] ERR_IMPL = 32'h9fffffff;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic [NRM_W-1:0] nrm;
		logic [EXT_W-1:0] ext;
		logic [ERR_W-1:0] err;
	} irq_src_s;

	typedef struct packed {
		logic [NRM_W-1:0] nrm;
		logic [EXT_W-1:0] ext;
		logic [ERR_W-1:0] err;
	} level_mask_s;
endpackage

// ### tb/event_source_model.sv
/*
 * Far-side event sources: one-cycle normal and error pulses, external lines held by their devices.
 * Assumes the bench changes its strobes right after a rising edge of ref_clk.
 */
module event_source_model (
	input wire logic ref_clk, // System bus clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic [21:0] fire_nrm, // Normal events, one cycle
	input wire logic [31:0] fire_err, // Error events, one cycle
	input wire logic [3:0] ext_raise, // Devices raising their lines
	input wire logic [3:0] ext_clear, // Devices cleared by software
	output irq_status_mask_pkg::irq_src_s src // Lines into the block
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] ext_q;
	// A line only drops on reset or when software clears it at the device
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			ext_q <= 4'h0;
		else
			ext_q <= (ext_q | ext_raise) & ~ext_clear;
	end
	assign src = '{nrm: fire_nrm, ext: ext_q, err: fire_err};
endmodule

// ### tb/test_irq_status_mask.sv
/*
 * Self-checking bench: random events, clears and mask writes, compared with an integer model.
 * Assumes read data one cycle after the strobe and level requests on the same edge as latched status, one edge after external lines.
 */
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("mismatch t=%0t %h %h", $time, a, b); end end
module test_irq_status_mask;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic rstn = 1'b1;
	irq_status_mask_pkg::reg_req_s req = '0;
	logic [31:0] rdata;
	irq_status_mask_pkg::irq_src_s src;
	logic [2:0] level_req;
	logic write_split;
	logic [21:0] fire_nrm = 22'h0;
	logic [31:0] fire_err = 32'h0;
	logic [3:0] ext_raise = 4'h0;
	logic [3:0] ext_clear = 4'h0;
	logic [31:0] lfsr_q = 32'hfc9a8ba1;
	logic [21:0] nrm_m;
	logic [31:0] err_m;
	logic [3:0] ext_m;
	logic split_m;
	logic [31:0] mask_m [0:8];
	logic [31:0] addrs [0:13];
	int fails = 0;
	int checks = 0;
	always #5 ref_clk = ~ref_clk;
	irq_status_mask i_irq_status_mask (.ref_clk, .rstn, .req, .rdata, .src, .level_req, .write_split);
	event_source_model i_event_source_model (.ref_clk, .rstn, .fire_nrm, .fire_err, .ext_raise, .ext_clear, .src);
	function automatic logic [31:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction
	function automatic logic [31:0] model_rd(input int k);
		case (k)
			0: return {split_m, 31'h0};
			1: return {|err_m, |ext_m, 8'h0, nrm_m};
			2: return {28'h0, ext_m};
			3: return err_m;
			13: return 32'h0;
			default: return mask_m[k - 4];
		endcase
	endfunction
	function automatic logic [2:0] model_lvl();
		for (int l = 0; l < 3; l++)
			model_lvl[l] = |(nrm_m & mask_m[3 * l][21:0]) | |(ext_m & mask_m[3 * l + 1][3:0]) | |(err_m & mask_m[3 * l + 2]);
	endfunction
	task automatic wr(input int k, input logic [31:0] d);
		@(posedge ref_clk);
		req <= '{addr: addrs[k], wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req.wr <= 1'b0;
		case (k)
			0: split_m = d[31];
			1: nrm_m = nrm_m & ~d[21:0];
			3: err_m = err_m & ~d;
			2, 13: ;
			default: mask_m[k - 4] = d & ((k - 4) % 3 == 0 ? 32'h003fffff : (k - 4) % 3 == 1 ? 32'h0000000f : 32'h9fffffff);
		endcase
	endtask
	task automatic rd_chk(input int k);
		@(posedge ref_clk);
		req <= '{addr: addrs[k], wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		@(negedge ref_clk);
		`CHK(rdata, model_rd(k))
	endtask
	task automatic fire(input logic [31:0] n, input logic [31:0] e, input logic [31:0] r, input logic [31:0] c);
		@(posedge ref_clk);
		fire_nrm <= n[21:0];
		fire_err <= e;
		ext_raise <= r[3:0];
		ext_clear <= c[3:0];
		@(posedge ref_clk);
		fire_nrm <= 22'h0;
		fire_err <= 32'h0;
		ext_raise <= 4'h0;
		ext_clear <= 4'h0;
		nrm_m = nrm_m | n[21:0];
		err_m = err_m | (e & 32'h9fffffff);
		ext_m = (ext_m | r[3:0]) & ~c[3:0];
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK({29'h0, level_req}, {29'h0, model_lvl()})
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		rstn <= 1'b0;
		nrm_m = 22'h0;
		err_m = 32'h0;
		ext_m = 4'h0;
		split_m = 1'b0;
		for (int i = 0; i < 9; i++)
			mask_m[i] = 32'h0;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		for (int k = 0; k < 14; k++)
			rd_chk(k);
		`CHK({29'h0, level_req}, 32'h0)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		fails++;
		tally_and_finish();
	end
	initial
	begin
		addrs = '{irq_status_mask_pkg::ADDR_SPLIT_CTRL, irq_status_mask_pkg::ADDR_NRM_STATUS,
			irq_status_mask_pkg::ADDR_EXT_STATUS, irq_status_mask_pkg::ADDR_ERR_STATUS,
			irq_status_mask_pkg::ADDR_L2_NRM_MASK, irq_status_mask_pkg::ADDR_L2_EXT_MASK,
			irq_status_mask_pkg::ADDR_L2_ERR_MASK, irq_status_mask_pkg::ADDR_L4_NRM_MASK,
			irq_status_mask_pkg::ADDR_L4_EXT_MASK, irq_status_mask_pkg::ADDR_L4_ERR_MASK,
			irq_status_mask_pkg::ADDR_L6_NRM_MASK, irq_status_mask_pkg::ADDR_L6_EXT_MASK,
			irq_status_mask_pkg::ADDR_L6_ERR_MASK, 32'h005f690c};
		// A falling edge is needed for the asynchronous reset to act before the first clock
		rstn <= 1'b0;
		do_reset();
		for (int it = 0; it < 40; it++)
		begin
			wr(4 + int'(rnd() % 9), rnd());
			fire(rnd() & rnd(), rnd() & rnd(), rnd(), rnd());
			for (int k = 0; k < 4; k++)
				wr(k, rnd());
			wr(13, rnd());
			@(negedge ref_clk);
			`CHK({31'h0, write_split}, {31'h0, split_m})
			for (int k = 0; k < 14; k++)
				rd_chk(k);
			`CHK({29'h0, level_req}, {29'h0, model_lvl()})
			if (it == 20)
				do_reset();
		end
		tally_and_finish();
	end
endmodule
